// File: src/fbg_baud_generator.sv
// Per-channel fractional baud rate generator with prescaler and sampling mode select
`timescale 1ns/1ns
module fbg_baud_generator
  import fbg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic sample_tick_o,
  output logic bit_tick_o,
  output fbg_cfg_type cfg_o
);

  // Register file
  logic [7:0] div_low, next_div_low;
  logic [7:0] div_high, next_div_high;
  logic [3:0] div_frac, next_div_frac;
  logic [7:0] eight_x, next_eight_x;
  logic [7:0] four_x, next_four_x;
  logic [7:0] modem_ctrl, next_modem_ctrl;
  logic [7:0] rdata, next_rdata;

  // Divider state
  logic [1:0] presc_cnt, next_presc_cnt;
  logic [INT_W:0] div_cnt, next_div_cnt;
  logic [FRAC_W-1:0] frac_acc, next_frac_acc;
  logic [3:0] samp_cnt, next_samp_cnt;
  logic sample_tick, next_sample_tick;
  logic bit_tick, next_bit_tick;

  logic [INT_W-1:0] int_div;
  logic [INT_W-1:0] int_eff;
  logic [FRAC_W-1:0] frac_sum;
  logic stretch;
  logic pre_tick;
  logic period_end;
  logic div_write;
  logic [3:0] samp_last;
  fbg_mode_type mode;

  // Integer part from both bytes; zero is held at one so the divider never stalls
  assign int_div = {div_high, div_low}; // R7 R12
  assign int_eff = (int_div == 16'h0000) ? 16'h0001 : int_div; // R3
  // Accumulator carry picks which periods get one extra prescaled clock
  assign {stretch, frac_sum} = {1'b0, frac_acc} + {1'b0, div_frac}; // R13
  // Prescaled clock enable, every cycle or every fourth
  assign pre_tick = !modem_ctrl[PRESC_BIT] || (presc_cnt == PRESC_LAST); // R1 R2
  assign period_end = pre_tick &&
    (div_cnt == ({1'b0, int_eff} - 17'h00001 + {16'h0000, stretch})); // R3 R13
  assign div_write = reg_wr_i &&
    (reg_sel_i == SEL_DIV_LOW || reg_sel_i == SEL_DIV_HIGH || reg_sel_i == SEL_DIV_FRAC);

  // Sampling mode decode; the reserved code falls back to 16x
  always_comb begin
    mode = FBG_SAMPLE_16X; // R9
    samp_last = LAST_16X;
    if (eight_x == MODE_SEL_ON && four_x == MODE_SEL_OFF) begin
      mode = FBG_SAMPLE_8X; // R9
      samp_last = LAST_8X;
    end else if (eight_x == MODE_SEL_OFF && four_x == MODE_SEL_ON) begin
      mode = FBG_SAMPLE_4X; // R9
      samp_last = LAST_4X;
    end
  end

  // Register writes and registered read data
  always_comb begin
    next_div_low = div_low;
    next_div_high = div_high;
    next_div_frac = div_frac;
    next_eight_x = eight_x;
    next_four_x = four_x;
    next_modem_ctrl = modem_ctrl;
    next_rdata = rdata;
    if (reg_wr_i) begin
      if (reg_sel_i == SEL_DIV_LOW) begin
        next_div_low = reg_wdata_i;
      end else if (reg_sel_i == SEL_DIV_HIGH) begin
        next_div_high = reg_wdata_i;
      end else if (reg_sel_i == SEL_DIV_FRAC) begin
        next_div_frac = reg_wdata_i[3:0]; // R8
      end else if (reg_sel_i == SEL_EIGHT_X) begin
        next_eight_x = reg_wdata_i;
      end else if (reg_sel_i == SEL_FOUR_X) begin
        next_four_x = reg_wdata_i;
      end else if (reg_sel_i == SEL_MODEM_CTRL) begin
        next_modem_ctrl = reg_wdata_i;
      end
    end
    if (reg_rd_i) begin
      if (reg_sel_i == SEL_DIV_LOW) begin
        next_rdata = div_low;
      end else if (reg_sel_i == SEL_DIV_HIGH) begin
        next_rdata = div_high;
      end else if (reg_sel_i == SEL_DIV_FRAC) begin
        next_rdata = {4'h0, div_frac}; // R8
      end else if (reg_sel_i == SEL_EIGHT_X) begin
        next_rdata = eight_x;
      end else if (reg_sel_i == SEL_FOUR_X) begin
        next_rdata = four_x;
      end else if (reg_sel_i == SEL_MODEM_CTRL) begin
        next_rdata = modem_ctrl;
      end else begin
        next_rdata = 8'h00; // Unmapped select reads zero
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      div_low <= RST_DIV_LOW; // R5
      div_high <= RST_DIV_HIGH; // R5
      div_frac <= RST_DIV_FRAC; // R5
      eight_x <= RST_MODE_SEL;
      four_x <= RST_MODE_SEL;
      modem_ctrl <= RST_MODEM_CTRL;
      rdata <= 8'h00;
    end else begin
      div_low <= next_div_low;
      div_high <= next_div_high;
      div_frac <= next_div_frac;
      eight_x <= next_eight_x;
      four_x <= next_four_x;
      modem_ctrl <= next_modem_ctrl;
      rdata <= next_rdata;
    end
  end

  // Divider next state; a divisor write restarts the period, fraction and sample counts; the prescaler count runs on
  always_comb begin
    next_presc_cnt = modem_ctrl[PRESC_BIT] ? presc_cnt + 2'h1 : 2'h0; // R2
    next_div_cnt = div_cnt;
    next_frac_acc = frac_acc;
    next_samp_cnt = samp_cnt;
    next_sample_tick = 1'b0;
    next_bit_tick = 1'b0;
    if (div_write) begin
      next_div_cnt = 17'h00000;
      next_frac_acc = 4'h0;
      next_samp_cnt = 4'h0;
    end else if (period_end) begin
      next_div_cnt = 17'h00000;
      next_frac_acc = frac_sum; // R13
      next_sample_tick = 1'b1; // R4
      // Wrap with >= so a mode change mid-bit cannot run the count away
      if (samp_cnt >= samp_last) begin
        next_samp_cnt = 4'h0;
        next_bit_tick = 1'b1; // R11
      end else begin
        next_samp_cnt = samp_cnt + 4'h1;
      end
    end else if (pre_tick) begin
      next_div_cnt = div_cnt + 17'h00001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      presc_cnt <= 2'h0;
      div_cnt <= 17'h00000;
      frac_acc <= 4'h0;
      samp_cnt <= 4'h0;
      sample_tick <= 1'b0;
      bit_tick <= 1'b0;
    end else begin
      presc_cnt <= next_presc_cnt;
      div_cnt <= next_div_cnt;
      frac_acc <= next_frac_acc;
      samp_cnt <= next_samp_cnt;
      sample_tick <= next_sample_tick;
      bit_tick <= next_bit_tick;
    end
  end

  // Jitter of one sixteenth in 8x mode with odd fractions is inherent to stretching
  assign sample_tick_o = sample_tick; // R4 R10
  assign bit_tick_o = bit_tick;
  assign reg_rdata_o = rdata;
  assign cfg_o = '{int_div: int_div, frac: div_frac,
                   presc_div4: modem_ctrl[PRESC_BIT], mode: mode};

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_reset_div_one: assert property ($rose(rst_n_i) |-> // R5
    (int_div == 16'h0001 && div_frac == 4'h0)) else $error("divisor not one after reset");
  a_presc_bypass: assert property (!modem_ctrl[PRESC_BIT] |-> pre_tick) // R2
    else $error("prescaler not bypassed");
  // Three quiet prescaler phases follow every enable while divide by four stays selected
  a_presc_quarter: assert property (modem_ctrl[PRESC_BIT] && pre_tick && !reg_wr_i // R2
    ##1 modem_ctrl[PRESC_BIT][*3] |-> !pre_tick && !$past(pre_tick) && !$past(pre_tick, 2))
    else $error("prescaler not divide by four");
  a_int_compose: assert property (cfg_o.int_div == {div_high, div_low}) // R12 R7
    else $error("integer divisor composition wrong");
  a_frac_read: assert property (reg_rd_i && reg_sel_i == SEL_DIV_FRAC |=> // R8
    reg_rdata_o[7:4] == 4'h0 && reg_rdata_o[3:0] == $past(div_frac))
    else $error("fraction readback wrong");
  a_nofrac_period: assert property (sample_tick && div_frac == 4'h0 // R3
    && !modem_ctrl[PRESC_BIT] && int_div == 16'h0003 && !reg_wr_i ##1 !reg_wr_i[*2]
    |-> ##1 sample_tick)
    else $error("integer period wrong");
  a_stretch_zero: assert property (div_frac == 4'h0 |-> !stretch) // R13
    else $error("stretch without fraction");
  a_bit_is_sample: assert property (bit_tick |-> sample_tick) // R4 R11
    else $error("bit tick without sample tick");
  a_mode_reserved: assert property (eight_x == MODE_SEL_ON && four_x == MODE_SEL_ON |-> // R9
    mode == FBG_SAMPLE_16X) else $error("reserved mode not 16x");
  a_bit_span: assert property (bit_tick && mode == FBG_SAMPLE_4X && !div_write |-> // R11
    samp_cnt == 4'h0) else $error("bit counter not restarted");

  c_mode_8x: cover property (bit_tick && mode == FBG_SAMPLE_8X);
  c_mode_4x: cover property (bit_tick && mode == FBG_SAMPLE_4X);
  c_stretched: cover property (period_end && stretch);
  c_presc_on: cover property (sample_tick && modem_ctrl[PRESC_BIT]);

endmodule : fbg_baud_generator

// File: src/fbg_pkg.sv
// Constants, types and register selects for the fractional baud rate generator
// Functional notes
// R1: Each channel owns one generator, clocked by the shared oscillator clock.
// R2: Prescaler divides input clock by 1 or by 4, chosen by modem control bit 7.
// R3: Divisor runs from 1 to 65536 minus 1/16 in steps of 1/16.
// R4: One sampling tick times both transmit shifting and receive sampling.
// R5: Reset gives divisor one: low byte 0x01, high byte and fraction 0x00.
// R6: Software must program the divisor before use; reset rate is unusable.
// R7: Two integer bytes form the whole part, fraction register the sub-integer part.
// R8: Only fraction bits 3:0 exist; code 0 adds nothing, code 15 adds 15/16.
// R9: Mode bytes 00/00 give 16x, FF/00 8x, 00/FF 4x; FF/FF is reserved.
// R10: 8x mode with an odd fraction shows bit-time jitter of 1/16; accepted.
// R11: One bit period spans 16, 8 or 4 sampling ticks per mode.
// R12: Integer divisor equals high byte times 256 plus low byte.
// R13: Fraction stretches that many periods per sixteen by one prescaled clock.
package fbg_pkg;

  localparam int INT_W = 16;
  localparam int FRAC_W = 4;

  // Register selects on the channel register port
  localparam logic [2:0] SEL_DIV_LOW = 3'h0;
  localparam logic [2:0] SEL_DIV_HIGH = 3'h1;
  localparam logic [2:0] SEL_DIV_FRAC = 3'h2;
  localparam logic [2:0] SEL_EIGHT_X = 3'h3;
  localparam logic [2:0] SEL_FOUR_X = 3'h4;
  localparam logic [2:0] SEL_MODEM_CTRL = 3'h5;

  // Reset values
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [3:0] RST_DIV_FRAC = 4'h0;
  localparam logic [7:0] RST_MODE_SEL = 8'h00;
  localparam logic [7:0] RST_MODEM_CTRL = 8'h00;

  // Field positions and codes
  localparam int PRESC_BIT = 7;
  localparam logic [1:0] PRESC_LAST = 2'h3;
  localparam logic [7:0] MODE_SEL_ON = 8'hFF;
  localparam logic [7:0] MODE_SEL_OFF = 8'h00;
  localparam logic [3:0] LAST_16X = 4'hF;
  localparam logic [3:0] LAST_8X = 4'h7;
  localparam logic [3:0] LAST_4X = 4'h3;

  typedef enum logic [1:0] {
    FBG_SAMPLE_16X,
    FBG_SAMPLE_8X,
    FBG_SAMPLE_4X
  } fbg_mode_type;

  typedef struct packed {
    logic [INT_W-1:0] int_div;
    logic [FRAC_W-1:0] frac;
    logic presc_div4;
    fbg_mode_type mode;
  } fbg_cfg_type;

endpackage : fbg_pkg

// File: dv/fbg_tick_monitor.sv
// Partner model: channel sampling logic counting sample ticks per bit
`timescale 1ns/1ns
module fbg_tick_monitor (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sample_tick_i,
  input wire logic bit_tick_i,
  output logic [7:0] ticks_per_bit_o,
  output logic lone_bit_o
);
  logic [7:0] cnt;
  // Shifting and sampling both step on the one sample tick
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt <= 8'h00;
      ticks_per_bit_o <= 8'h00;
      lone_bit_o <= 1'b0;
    end else begin
      if (sample_tick_i) begin
        cnt <= bit_tick_i ? 8'h00 : cnt + 8'h01;
      end
      if (bit_tick_i) begin
        ticks_per_bit_o <= cnt + 8'h01;
      end
      if (bit_tick_i && !sample_tick_i) begin
        lone_bit_o <= 1'b1;
      end
    end
  end
endmodule : fbg_tick_monitor

// File: dv/tb_top.sv
// Self-checking bench for the fractional baud rate generator
`timescale 1ns/1ns
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
  import fbg_pkg::*;
  logic clk_i = 0, rst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
  logic [2:0] reg_sel_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, tpb;
  logic sample_tick_o, bit_tick_o, lone;
  fbg_cfg_type cfg_o;
  int err_count = 0, checked = 0, cyc = 0, t0;
  logic [7:0] ex [4] = '{8'h00, 8'hFF, 8'h00, 8'hFF};
  logic [7:0] fx [4] = '{8'h00, 8'h00, 8'hFF, 8'hFF};
  logic [7:0] nb [4] = '{8'h10, 8'h08, 8'h04, 8'h10};
  logic [7:0] rst [6] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  fbg_mode_type md [4] = '{FBG_SAMPLE_16X, FBG_SAMPLE_8X, FBG_SAMPLE_4X, FBG_SAMPLE_16X};
  fbg_baud_generator fbg_baud_generator_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .sample_tick_o(sample_tick_o),
    .bit_tick_o(bit_tick_o), .cfg_o(cfg_o));
  fbg_tick_monitor fbg_tick_monitor_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .sample_tick_i(sample_tick_o), .bit_tick_i(bit_tick_o), .ticks_per_bit_o(tpb),
    .lone_bit_o(lone));
  // Free-running 50 MHz clock, shared by every channel generator
  always #10 clk_i = ~clk_i;
  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  // Clocks spanned by sixteen sample ticks; the fraction stretches that many periods
  function automatic int exp_period(input logic p, input logic [15:0] d, input logic [3:0] f);
    return (p ? 4 : 1) * (16 * int'(d) + int'(f));
  endfunction : exp_period
  // Worst test is well under this; a hang ends the run as a failure
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 60000) begin
      err_count++;
      finish_test();
    end
  end
  // Strobe stays low for an edge between accesses, so tasks can chain
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    reg_sel_i = s;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge clk_i);
    #1;
    reg_wr_i = 1'b0;
    @(posedge clk_i);
    #1;
  endtask : wr
  task automatic rd(input logic [2:0] s, output logic [7:0] d);
    reg_sel_i = s;
    reg_rd_i = 1'b1;
    @(posedge clk_i);
    #1;
    reg_rd_i = 1'b0;
    @(posedge clk_i);
    #1;
    d = reg_rdata_o;
  endtask : rd
  task automatic wait_tick(input logic b);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (((b ? bit_tick_o : sample_tick_o) !== 1'b1) && n < 5000);
  endtask : wait_tick
  task automatic chk_reset();
    logic [7:0] v;
    for (int s = 0; s < 6; s++) begin
      rd(3'(s), v);
      `CHK("reset reg", rst[s], v)
    end
    `CHK("reset div", 16'h0001, cfg_o.int_div)
  endtask : chk_reset
  initial begin
    logic [15:0] dv;
    logic [3:0] fr;
    logic pr;
    logic [7:0] rv;
    int m;
    void'($urandom(32'ha3b8fa2c));
    repeat (8) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    chk_reset();
    wr(3'h7, 8'h5A);
    rd(3'h6, rv);
    `CHK("unmapped", 8'h00, rv)
    rd(SEL_DIV_LOW, rv);
    `CHK("low kept", 8'h01, rv)
    // Corners first: smallest divisor with top fraction, high byte only, plain divide by three
    for (int i = 0; i < 12; i++) begin
      dv = (i == 0) ? 16'h0001 : (i == 1) ? 16'h0100 : (i == 2) ? 16'h0003 :
        16'($urandom_range(9, 2));
      fr = (i == 0) ? 4'hF : (i == 2) ? 4'h0 : 4'($urandom);
      pr = (i < 3) ? 1'b0 : 1'($urandom);
      m = i % 4;
      wr(SEL_EIGHT_X, ex[m]);
      wr(SEL_FOUR_X, fx[m]);
      wr(SEL_MODEM_CTRL, {pr, 7'h00});
      wr(SEL_DIV_HIGH, dv[15:8]);
      wr(SEL_DIV_LOW, dv[7:0]);
      wr(SEL_DIV_FRAC, {4'($urandom), fr});
      `CHK("int_div", dv, cfg_o.int_div)
      `CHK("frac", fr, cfg_o.frac)
      `CHK("presc", pr, cfg_o.presc_div4)
      `CHK("mode", md[m], cfg_o.mode)
      rd(SEL_DIV_FRAC, rv);
      `CHK("frac reg", {4'h0, fr}, rv)
      wait_tick(1'b0);
      t0 = cyc;
      repeat (16) wait_tick(1'b0);
      `CHK("period", exp_period(pr, dv, fr), cyc - t0)
      repeat (2) wait_tick(1'b1);
      // The monitor latches its count on the edge after the bit tick shows
      @(posedge clk_i);
      #1;
      `CHK("ticks per bit", nb[m], tpb)
      `CHK("lone bit", 1'b0, lone)
      $display("test %0d done", i);
    end
    rst_n_i = 1'b0;
    @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    chk_reset();
    $display("test reset done");
    finish_test();
  end
endmodule : tb_top
